// File: core/break_sequencer.sv
// Purpose: enters and leaves the break state for the processor
// Assumes: all inputs come from logic on hclk
// Notes: entry loads the software interrupt opcode and the break vector
`timescale 1ns/1ns
`include "sim_regs.svh"
module break_sequencer (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // power-on reset, active low
  input wire logic break_req, // break address match, level
  input wire logic instr_last_cycle, // current instruction in its last cycle
  input wire logic wait_mode, // processor waiting, no instruction running
  input wire logic monitor_mode, // monitor mode selects the alternate vector
  input wire logic return_done, // return_from_interrupt completed
  output logic active, // break state
  output logic ir_load, // pulse: load opcode into instruction register
  output logic pc_load, // pulse: load program counter with vector
  output logic [15:0] pc_vector, // vector address
  output logic wait_exit // pulse: break ended wait mode
);

  sim_pkg::break_seq_state_t r;
  sim_pkg::break_seq_state_t n;

  always_comb begin
    n = r;
    n.ir_load = 1'b0;
    n.pc_load = 1'b0;
    n.wait_exit = 1'b0;
    unique case (r.state)
      sim_pkg::BRK_IDLE: begin
        if (break_req) begin
          if (instr_last_cycle || wait_mode) begin
            n.state = sim_pkg::BRK_ACTIVE;
            n.ir_load = 1'b1;
            n.pc_load = 1'b1;
            n.wait_exit = wait_mode;
          end else begin
            n.state = sim_pkg::BRK_PENDING;
          end
        end
      end
      sim_pkg::BRK_PENDING: begin
        // a processor that went to wait meanwhile runs no instruction
        if (instr_last_cycle || wait_mode) begin
          n.state = sim_pkg::BRK_ACTIVE;
          n.ir_load = 1'b1;
          n.pc_load = 1'b1;
          n.wait_exit = wait_mode;
        end
      end
      sim_pkg::BRK_ACTIVE: begin
        if (return_done && !break_req) begin
          n.state = sim_pkg::BRK_IDLE;
        end
      end
    endcase
    n.pc_vector = monitor_mode ? `BREAK_VECTOR_MONITOR : `BREAK_VECTOR_NORMAL;
    n.active = (n.state == sim_pkg::BRK_ACTIVE);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{state: sim_pkg::BRK_IDLE, pc_vector: `BREAK_VECTOR_NORMAL, default: '0};
    end else begin
      r <= n;
    end
  end

  assign active = r.active;
  assign ir_load = r.ir_load;
  assign pc_load = r.pc_load;
  assign pc_vector = r.pc_vector;
  assign wait_exit = r.wait_exit;

endmodule : break_sequencer

// File: core/reset_cause_capture.sv
// Purpose: brings non-power-on reset requests into the bus clock and marks their onset
// Assumes: requests are levels from outside the clock domain
// Notes: bit 0 pin, bit 1 watchdog, bit 2 low voltage
`timescale 1ns/1ns
module reset_cause_capture (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // power-on reset, active low
  input wire logic [2:0] req_async, // reset requests, asynchronous levels
  output logic [2:0] onset // one-cycle pulse per request onset
);

  sim_pkg::capture_state_t r;
  sim_pkg::capture_state_t n;

  always_comb begin
    n = r;
    n.sync1 = req_async;
    n.sync2 = r.sync1;
    n.prev = r.sync2;
    n.events = r.sync2 & ~r.prev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign onset = r.events;

endmodule : reset_cause_capture

// File: core/sim_pkg.sv
// Purpose: state types of the reset cause and break status group
// Assumes: constants come from sim_regs.svh
// Notes: one packed struct per module holds its state; the top module keeps opcode_reg outside it
package sim_pkg;

  typedef enum logic [1:0] {
    BRK_IDLE,
    BRK_PENDING,
    BRK_ACTIVE
  } break_state_t;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    logic [2:0] events;
  } capture_state_t;

  typedef struct packed {
    break_state_t state;
    logic active;
    logic ir_load;
    logic pc_load;
    logic [15:0] pc_vector;
    logic wait_exit;
  } break_seq_state_t;

  typedef struct packed {
    logic [7:0] reset_cause;
    logic wait_exit;
    logic bce;
    logic [15:0] int_flags;
    logic data_wr;
    logic [15:0] data_idx;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic clear_allow;
  } top_state_t;

endpackage : sim_pkg

// File: core/sim_regs.svh
// Purpose: register indices, field positions, reset values and vectors of the status group
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef SIM_REGS_SVH
`define SIM_REGS_SVH

// register indices (byte address = index * 4)
`define IDX_BREAK_WAIT_STATUS 16'hFE00
`define IDX_RESET_CAUSE_STATUS 16'hFE01
`define IDX_BREAK_FLAG_CONTROL 16'hFE03
`define IDX_INT_STATUS_LOW 16'hFE04
`define IDX_INT_STATUS_MID 16'hFE05
`define IDX_INT_STATUS_HIGH 16'hFE06

// address split
`define IDX_LSB 2
`define IDX_MSB 17

// field positions
`define CLEAR_ENABLE_BIT 7
`define WAIT_EXIT_BIT 1
`define RC_POR_BIT 7
`define RC_PIN_BIT 6
`define RC_WDOG_BIT 5
`define RC_LVD_BIT 1
`define INT_LOW_SHIFT 2

// reset values
`define BREAK_FLAG_CONTROL_RESET 8'h00
`define CLEAR_ENABLE_RESET 1'b0
`define RESET_CAUSE_POR_VALUE 8'h80
`define INT_STATUS_RESET 16'h0000

// break vectors
`define BREAK_VECTOR_NORMAL 16'hFFFC
`define BREAK_VECTOR_MONITOR 16'hFEFC

`endif

// File: core/sim_reset_break_status.sv
// Purpose: reset cause, break wait and interrupt source status registers on AHB-Lite
// Assumes: hresetn is the power-on reset; other reset sources arrive as request levels
// Notes: zero wait states; sub-word accesses at byte offset 0 act on the whole word, other offsets hit no register
`timescale 1ns/1ns
`include "sim_regs.svh"

module sim_reset_break_status #(
  parameter int ADDR_WIDTH = 32, // haddr width
  parameter logic [7:0] TRAP_OPCODE = 8'h00 // opcode value, plain default
) (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // power-on reset, active low
  input wire logic hsel, // slave select
  input wire logic [ADDR_WIDTH-1:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word expected
  input wire logic hready, // bus ready
  input wire logic [31:0] hwdata, // write data
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // response, always okay
  input wire logic pin_reset_req, // external pin reset, asynchronous level
  input wire logic watchdog_reset_req, // watchdog reset, asynchronous level
  input wire logic lvd_reset_req, // low-voltage reset, asynchronous level
  input wire logic [15:0] irq_flags, // interrupt source flags, index 0 is the first
  input wire logic break_req, // break address match
  input wire logic instr_last_cycle, // last cycle of current instruction
  input wire logic wait_mode, // processor in wait mode
  input wire logic monitor_mode, // monitor mode
  input wire logic return_done, // return_from_interrupt completed
  output logic break_active, // break state
  output logic ir_load, // pulse: load software_interrupt_opcode
  output logic [7:0] ir_opcode, // software_interrupt_opcode value
  output logic pc_load, // pulse: load break vector
  output logic [15:0] pc_vector, // break vector
  output logic status_clear_allow // other modules may clear status bits
);

  if (ADDR_WIDTH < `IDX_MSB + 1) begin : g_addr_check
    $error("ADDR_WIDTH too small for register map");
  end

  logic [2:0] onset;
  logic brk_active;
  logic brk_ir_load;
  logic brk_pc_load;
  logic [15:0] brk_vector;
  logic brk_wait_exit;
  logic [7:0] opcode_reg;

  sim_pkg::top_state_t r;
  sim_pkg::top_state_t n;

  reset_cause_capture u_capture (
    .hclk(hclk),
    .hresetn(hresetn),
    .req_async({lvd_reset_req, watchdog_reset_req, pin_reset_req}),
    .onset(onset)
  );

  break_sequencer u_break (
    .hclk(hclk),
    .hresetn(hresetn),
    .break_req(break_req),
    .instr_last_cycle(instr_last_cycle),
    .wait_mode(wait_mode),
    .monitor_mode(monitor_mode),
    .return_done(return_done),
    .active(brk_active),
    .ir_load(brk_ir_load),
    .pc_load(brk_pc_load),
    .pc_vector(brk_vector),
    .wait_exit(brk_wait_exit)
  );

  // register index of a byte address, all ones when misaligned or above the index bits
  function automatic logic [15:0] reg_index(input logic [ADDR_WIDTH-1:0] addr);
    logic [ADDR_WIDTH-1:0] upper;
    upper = addr >> (`IDX_MSB + 1);
    if (upper != '0 || addr[1:0] != 2'h0) begin
      reg_index = 16'hFFFF;
    end else begin
      reg_index = addr[`IDX_MSB:`IDX_LSB];
    end
  endfunction : reg_index

  // read value of one register
  function automatic logic [7:0] read_value(
    input logic [15:0] idx,
    input logic bce,
    input logic wexit,
    input logic [7:0] cause,
    input logic [15:0] flags
  );
    read_value = 8'h00;
    case (idx)
      `IDX_BREAK_FLAG_CONTROL: read_value[`CLEAR_ENABLE_BIT] = bce;
      `IDX_BREAK_WAIT_STATUS: read_value[`WAIT_EXIT_BIT] = wexit;
      `IDX_RESET_CAUSE_STATUS: read_value = cause;
      `IDX_INT_STATUS_LOW: read_value = {flags[5:0], 2'h0};
      `IDX_INT_STATUS_MID: read_value = flags[13:6];
      `IDX_INT_STATUS_HIGH: read_value = {6'h00, flags[15:14]};
      default: read_value = 8'h00;
    endcase
  endfunction : read_value

  logic accept;
  logic allow;
  logic [15:0] idx;
  logic [7:0] rd_value;
  logic [7:0] clear_mask;
  logic [7:0] set_mask;

  always_comb begin
    n = r;
    n.hresp = 1'b0;
    n.hreadyout = 1'b1;
    clear_mask = 8'h00;
    set_mask = 8'h00;
    allow = !brk_active || r.bce;
    n.clear_allow = allow;
    n.int_flags = irq_flags;

    // data phase of a write taken in the previous cycle
    if (r.data_wr) begin
      case (r.data_idx)
        `IDX_BREAK_FLAG_CONTROL: n.bce = hwdata[`CLEAR_ENABLE_BIT];
        `IDX_BREAK_WAIT_STATUS: begin
          if (!hwdata[`WAIT_EXIT_BIT] && allow) begin
            n.wait_exit = 1'b0;
          end
        end
        default: n.bce = n.bce;
      endcase
    end
    // set wins over a clear in the same cycle
    if (brk_wait_exit) begin
      n.wait_exit = 1'b1;
    end

    accept = hsel && htrans[1] && hready;
    idx = reg_index(haddr);
    // read sees a write completing in the same cycle
    rd_value = read_value(idx, n.bce, n.wait_exit, r.reset_cause, r.int_flags);
    n.data_wr = accept && hwrite;
    n.data_idx = idx;
    if (accept && !hwrite) begin
      n.hrdata = {24'h000000, rd_value};
      if (idx == `IDX_RESET_CAUSE_STATUS && allow) begin
        clear_mask = r.reset_cause;
      end
    end

    set_mask[`RC_PIN_BIT] = onset[0];
    set_mask[`RC_WDOG_BIT] = onset[1];
    set_mask[`RC_LVD_BIT] = onset[2];
    // only bits reported by the read are cleared; new sources keep theirs
    n.reset_cause = (r.reset_cause & ~clear_mask) | set_mask;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{reset_cause: `RESET_CAUSE_POR_VALUE,
             bce: `CLEAR_ENABLE_RESET,
             int_flags: `INT_STATUS_RESET,
             hreadyout: 1'b1,
             clear_allow: 1'b1,
             default: '0};
      opcode_reg <= 8'h00;
    end else begin
      r <= n;
      opcode_reg <= TRAP_OPCODE;
    end
  end

  assign hrdata = r.hrdata;
  assign hreadyout = r.hreadyout;
  assign hresp = r.hresp;
  assign status_clear_allow = r.clear_allow;
  assign break_active = brk_active;
  assign ir_load = brk_ir_load;
  assign ir_opcode = opcode_reg;
  assign pc_load = brk_pc_load;
  assign pc_vector = brk_vector;

endmodule : sim_reset_break_status

// File: dv/cpu_core_model.sv
// Purpose: processor side of the break handshake
// Assumes: three-cycle instructions
// Notes: return fires in the sixth cycle of a break, then every eighth cycle
`timescale 1ns/1ns
module cpu_core_model (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset
  input wire logic go, // break wanted
  input wire logic wait_en, // processor waits
  input wire logic mon, // monitor mode
  input wire logic break_active, // break state
  output logic break_req, // address match
  output logic instr_last_cycle, // last cycle
  output logic wait_mode, // waiting
  output logic monitor_mode, // monitor
  output logic return_done // return done
);
  logic [1:0] cyc;
  logic [2:0] rt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc <= 2'h0;
      rt <= 3'h0;
    end else begin
      cyc <= (cyc == 2'h2) ? 2'h0 : cyc + 2'h1;
      rt <= break_active ? rt + 3'h1 : 3'h0;
    end
  end
  // no instruction runs while waiting
  assign instr_last_cycle = !wait_en && cyc == 2'h2;
  assign return_done = rt == 3'h5;
  assign wait_mode = wait_en;
  assign monitor_mode = mon;
  assign break_req = go;
endmodule : cpu_core_model

// File: dv/sim_props.sv
// Purpose: checks on break sequencing and bus replies
// Assumes: sees the top module ports only
// Notes: bind after endmodule
`timescale 1ns/1ns
module sim_props (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset
  input wire logic break_req, // break ask
  input wire logic instr_last_cycle, // last cycle
  input wire logic wait_mode, // waiting
  input wire logic monitor_mode, // monitor
  input wire logic return_done, // return done
  input wire logic break_active, // in break
  input wire logic ir_load, // opcode load
  input wire logic pc_load, // vector load
  input wire logic [15:0] pc_vector, // vector
  input wire logic [31:0] hrdata, // read data
  input wire logic hreadyout, // ready
  input wire logic hresp // response
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_ask;
    !break_active && break_req;
  endsequence
  sequence s_entry;
    ir_load && pc_load && break_active;
  endsequence
  a_entry_now: assert property (s_ask ##0 instr_last_cycle |=> s_entry)
    else $error("break did not start at last cycle");
  a_entry_wait: assert property (s_ask ##0 wait_mode |=> s_entry)
    else $error("break did not start from wait");
  a_no_early: assert property (!break_active && !instr_last_cycle && !wait_mode |=> !ir_load)
    else $error("break started mid instruction");
  a_load_once: assert property (ir_load |=> !ir_load && !pc_load)
    else $error("load pulse too long");
  a_vec_pick: assert property (pc_load |-> pc_vector == ($past(monitor_mode) ? 16'hFEFC : 16'hFFFC))
    else $error("wrong break vector");
  a_return_end: assert property (break_active && return_done && !break_req |=> !break_active)
    else $error("break not ended by return");
  a_return_held: assert property (break_active && break_req |=> break_active)
    else $error("break ended while requested");
  a_bus_okay: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h0)
    else $error("bus reply or upper data wrong");
endmodule : sim_props

bind sim_reset_break_status sim_props u_props (.hclk, .hresetn, .break_req, .instr_last_cycle,
  .wait_mode, .monitor_mode, .return_done, .break_active, .ir_load, .pc_load, .pc_vector, .hrdata,
  .hreadyout, .hresp);

// File: dv/sim_reset_break_status_test.sv
// Purpose: register and break checks of the status group
// Assumes: zero wait states on the bus
// Notes: table first, then hand tests
`timescale 1ns/1ns
`include "sim_regs.svh"
module sim_reset_break_status_test;
  typedef struct packed {logic w; logic [15:0] idx; logic [15:0] irq; logic [7:0] d, e;} row_t;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] irq_flags, pc_vector;
  logic pin_reset_req, watchdog_reset_req, lvd_reset_req, go, wait_en, mon;
  logic break_req, instr_last_cycle, wait_mode, monitor_mode, return_done;
  logic break_active, ir_load, pc_load, status_clear_allow;
  logic [7:0] ir_opcode, rd;
  int bad_count = 0, n_tests = 0, cycles = 0;
  row_t rows [12] = '{'{1'h0, 16'hFE01, 16'h0, 8'h0, 8'h80}, '{1'h0, 16'hFE01, 16'h0, 8'h0, 8'h0},
    '{1'h0, 16'hFE03, 16'h0, 8'h0, 8'h0}, '{1'h1, 16'hFE03, 16'h0, 8'h80, 8'h0},
    '{1'h0, 16'hFE03, 16'h0, 8'h0, 8'h80}, '{1'h1, 16'hFE03, 16'h0, 8'h0, 8'h0},
    '{1'h1, 16'hFE04, 16'h0, 8'hFF, 8'h0}, '{1'h0, 16'hFE04, 16'h0, 8'h0, 8'h0},
    '{1'h0, 16'hFE04, 16'hFFFF, 8'h0, 8'hFC}, '{1'h0, 16'hFE05, 16'hFFFF, 8'h0, 8'hFF},
    '{1'h0, 16'hFE06, 16'h4001, 8'h0, 8'h01}, '{1'h0, 16'hFE02, 16'hFFFF, 8'h0, 8'h0}};
  assign hready = hreadyout;
  sim_reset_break_status #(.TRAP_OPCODE(8'h5A)) u_dut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .pin_reset_req,
    .watchdog_reset_req, .lvd_reset_req, .irq_flags, .break_req, .instr_last_cycle, .wait_mode,
    .monitor_mode, .return_done,
    .break_active, .ir_load, .ir_opcode, .pc_load, .pc_vector, .status_clear_allow);
  cpu_core_model u_cpu (.hclk, .hresetn, .go, .wait_en, .mon, .break_active, .break_req,
    .instr_last_cycle, .wait_mode, .monitor_mode, .return_done);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {14'h0, idx, 2'h0};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata[7:0];
  endtask : xfer
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdc(input string nm, input logic [15:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h0);
    chk(nm, e, rd);
  endtask : rdc
  task automatic await(input logic v);
    int i;
    i = 0;
    while (break_active !== v && i < 40) begin
      @(posedge hclk);
      i++;
    end
    chk("break_active", {7'h0, v}, {7'h0, break_active});
  endtask : await
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, irq_flags, go, wait_en, mon} = '0;
    {pin_reset_req, watchdog_reset_req, lvd_reset_req} = 3'h0;
    hsize = 3'h2;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rows[i]) begin
      irq_flags <= rows[i].irq;
      @(posedge hclk);
      xfer(rows[i].w, rows[i].idx, rows[i].d);
      if (!rows[i].w) chk("table read", rows[i].e, rd);
    end
    chk("clear allow", 8'h01, {7'h0, status_clear_allow});
    chk("opcode", 8'h5A, ir_opcode);
    $display("table done");
    pin_reset_req <= 1'b1;
    lvd_reset_req <= 1'b1;
    repeat (6) @(posedge hclk);
    watchdog_reset_req <= 1'b1;
    repeat (6) @(posedge hclk);
    rdc("reset cause", `IDX_RESET_CAUSE_STATUS, 8'h62);
    rdc("reset cause", `IDX_RESET_CAUSE_STATUS, 8'h00);
    {pin_reset_req, watchdog_reset_req, lvd_reset_req} <= 3'h0;
    repeat (3) @(posedge hclk);
    $display("reset sources done");
    pin_reset_req <= 1'b1;
    wait_en <= 1'b1;
    go <= 1'b1;
    await(1'b1);
    wait_en <= 1'b0;
    repeat (4) @(posedge hclk);
    rdc("wait flag", `IDX_BREAK_WAIT_STATUS, 8'h02);
    xfer(1'b1, `IDX_BREAK_WAIT_STATUS, 8'h00);
    rdc("wait flag", `IDX_BREAK_WAIT_STATUS, 8'h02);
    rdc("reset cause", `IDX_RESET_CAUSE_STATUS, 8'h40);
    rdc("reset cause", `IDX_RESET_CAUSE_STATUS, 8'h40);
    chk("clear allow", 8'h00, {7'h0, status_clear_allow});
    chk("break held", 8'h01, {7'h0, break_active});
    go <= 1'b0;
    await(1'b0);
    xfer(1'b1, `IDX_BREAK_WAIT_STATUS, 8'h00);
    rdc("wait flag", `IDX_BREAK_WAIT_STATUS, 8'h00);
    $display("wait break done");
    xfer(1'b1, `IDX_BREAK_FLAG_CONTROL, 8'h80);
    mon <= 1'b1;
    go <= 1'b1;
    await(1'b1);
    chk("clear allow", 8'h01, {7'h0, status_clear_allow});
    rdc("reset cause", `IDX_RESET_CAUSE_STATUS, 8'h40);
    rdc("reset cause", `IDX_RESET_CAUSE_STATUS, 8'h00);
    rdc("wait flag", `IDX_BREAK_WAIT_STATUS, 8'h00);
    go <= 1'b0;
    await(1'b0);
    $display("monitor break done");
    // set a pin flag, then a power-on reset in mid-run must leave only its own flag
    pin_reset_req <= 1'b0;
    repeat (3) @(posedge hclk);
    pin_reset_req <= 1'b1;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b0;
    pin_reset_req <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("reset cause", `IDX_RESET_CAUSE_STATUS, 8'h80);
    rdc("reset cause", `IDX_RESET_CAUSE_STATUS, 8'h00);
    rdc("clear enable", `IDX_BREAK_FLAG_CONTROL, 8'h00);
    $display("second reset done");
    print_verdict();
  end
endmodule : sim_reset_break_status_test
